// >>> logic/bsr_pkg.sv
// Operation
// - Two 16x4 nibble RAMs form the store
// - Write on edge when strobe and enable
// - Read data driven straight from RAM
// - No reset clears the stored contents
// - Acknowledge follows strobe in zero-wait form
// - Read data valid at acknowledged edge
// - Asynchronous read keeps same-cycle acknowledge
// - Registered read adds one read wait
// - No clock limit beyond the RAM
// - Sixteen byte locations, 4-bit address
package bsr_pkg;

  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 8;
  localparam int NIB_W   = 4;
  localparam int DEPTH   = 16;
  localparam int LO_LSB  = 0;
  localparam int HI_LSB  = 4;

  // Read path state for the registered-read variant
  typedef enum logic [0:0]
  {
    BSR_RD_IDLE = 1'h0,
    BSR_RD_WAIT = 1'h1
  } bsr_rd_state_t;

endpackage

// >>> logic/bsr_nib_if.sv
`timescale 1ns/100ps
// Port of one nibble-wide RAM element
interface bsr_nib_if;
  logic [bsr_pkg::ADDR_W-1:0] addr;
  logic [bsr_pkg::NIB_W-1:0]  wdata;
  logic                       we;
  logic [bsr_pkg::NIB_W-1:0]  rdata;

  modport ram
  (
    input  addr,
    input  wdata,
    input  we,
    output rdata
  );

  modport ctrl
  (
    output addr,
    output wdata,
    output we,
    input  rdata
  );
endinterface

// >>> logic/bsr_nibble_ram.sv
`timescale 1ns/100ps
// One 16 x 4-bit synchronous-write RAM element
module bsr_nibble_ram
#(
  parameter bit SYNC_READ = 1'b0
)
(
  input wire logic  core_clk,
  bsr_nib_if.ram    port
);

  logic [bsr_pkg::NIB_W-1:0] mem [bsr_pkg::DEPTH];
  logic [bsr_pkg::NIB_W-1:0] rd_reg;

  // Storage has no reset, like most RAM primitives
  always_ff @(posedge core_clk)
  begin
    if (port.we)
    begin
      mem[port.addr] <= port.wdata;
    end
  end

  // Registered read output, used only in the synchronous-read form
  always_ff @(posedge core_clk)
  begin
    rd_reg <= mem[port.addr];
  end

  // Asynchronous read lets acknowledge follow strobe in the same cycle
  assign port.rdata = SYNC_READ ? rd_reg : mem[port.addr];

endmodule

// >>> logic/bsr_ram16x8.sv
`timescale 1ns/100ps
// Bus slave RAM of 16 bytes with a strobe and acknowledge handshake
module bsr_ram16x8
#(
  parameter bit SYNC_READ = 1'b0
)
(
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire logic [bsr_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [bsr_pkg::DATA_W-1:0] dat_i,
  output logic      [bsr_pkg::DATA_W-1:0] dat_o,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  output logic                            ack_o
);

  bsr_nib_if lo_if ();
  bsr_nib_if hi_if ();

  bsr_pkg::bsr_rd_state_t rd_state;
  bsr_pkg::bsr_rd_state_t next_rd_state;
  logic                   ram_we;

  // Read strobe decode shared by the wait logic and the checks
  function automatic logic is_read
  (
    input logic stb,
    input logic we
  );
    return stb & ~we;
  endfunction

  // Write enable is the plain AND of strobe and write enable
  assign ram_we = stb_i & we_i;

  // Low nibble and high nibble elements share address and enable
  assign lo_if.addr  = adr_i;
  assign lo_if.wdata = dat_i[bsr_pkg::LO_LSB +: bsr_pkg::NIB_W];
  assign lo_if.we    = ram_we;
  assign hi_if.addr  = adr_i;
  assign hi_if.wdata = dat_i[bsr_pkg::HI_LSB +: bsr_pkg::NIB_W];
  assign hi_if.we    = ram_we;

  // No gate of ours sits in the RAM path, so the element alone sets the speed
  bsr_nibble_ram #(.SYNC_READ(SYNC_READ)) u_lo
  (
    .core_clk (core_clk),
    .port     (lo_if.ram)
  );

  bsr_nibble_ram #(.SYNC_READ(SYNC_READ)) u_hi
  (
    .core_clk (core_clk),
    .port     (hi_if.ram)
  );

  // No output register: a register here would cost the zero-wait read
  assign dat_o = {hi_if.rdata, lo_if.rdata};

  // Zero-wait reads show the addressed byte, registered reads it at acknowledge
  async_read_data_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !SYNC_READ && is_read(stb_i, we_i) |-> dat_o == {u_hi.mem[adr_i], u_lo.mem[adr_i]})
    else $error("asynchronous read data is not the addressed byte");

  sync_read_data_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    SYNC_READ && ack_o && is_read(stb_i, we_i)
    |-> dat_o == {u_hi.mem[adr_i], u_lo.mem[adr_i]})
    else $error("registered read data is not the addressed byte");

  // One wait cycle per read, then idle again so block reads re-wait
  always_comb
  begin
    next_rd_state = bsr_pkg::BSR_RD_IDLE;
    case (rd_state)
      bsr_pkg::BSR_RD_IDLE:
        if (SYNC_READ && is_read(stb_i, we_i))
        begin
          next_rd_state = bsr_pkg::BSR_RD_WAIT;
        end
      bsr_pkg::BSR_RD_WAIT:
        next_rd_state = bsr_pkg::BSR_RD_IDLE;
      default:
        next_rd_state = bsr_pkg::BSR_RD_IDLE;
    endcase
  end

  // Reset touches the handshake flop, the shadow and the written flags, never the stored bytes
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_state <= bsr_pkg::BSR_RD_IDLE;
    end
    else
    begin
      rd_state <= next_rd_state;
    end
  end

  // A registered read answers only from the wait state; a write never starts one
  read_from_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ack_o && is_read(stb_i, we_i) && SYNC_READ |-> rd_state == bsr_pkg::BSR_RD_WAIT)
    else $error("registered read acknowledged outside the wait state");

  write_no_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    stb_i && we_i |=> rd_state == bsr_pkg::BSR_RD_IDLE)
    else $error("write cycle left a read wait pending");

  // Writes always acknowledge at once; reads wait only with registered RAM
  always_comb
  begin
    if (!SYNC_READ)
    begin
      ack_o = stb_i;
    end
    else
    begin
      ack_o = stb_i & (we_i | (rd_state == bsr_pkg::BSR_RD_WAIT));
    end
  end

  // Zero-wait form: acknowledge is strobe itself, reads and writes alike
  ack_is_stb_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !SYNC_READ |-> ack_o == stb_i)
    else $error("zero-wait acknowledge differs from strobe");

  // Shadow of the last write, read only by the checks below
  logic                      shadow_valid;
  logic [bsr_pkg::ADDR_W-1:0] shadow_addr;
  logic [bsr_pkg::DATA_W-1:0] shadow_data;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shadow_valid <= 1'h0;
      shadow_addr  <= 4'h0;
      shadow_data  <= 8'h00;
    end
    else if (ram_we)
    begin
      shadow_valid <= 1'h1;
      shadow_addr  <= adr_i;
      shadow_data  <= dat_i;
    end
  end

  // Each element keeps its own half of the last byte written
  lo_nibble_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    shadow_valid |-> u_lo.mem[shadow_addr] == shadow_data[bsr_pkg::LO_LSB +: bsr_pkg::NIB_W])
    else $error("low nibble element lost its half of the byte");

  hi_nibble_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    shadow_valid |-> u_hi.mem[shadow_addr] == shadow_data[bsr_pkg::HI_LSB +: bsr_pkg::NIB_W])
    else $error("high nibble element lost its half of the byte");

  // Reference copy of every byte written; flags clear on reset, bytes never do
  logic [bsr_pkg::DATA_W-1:0] model_mem [bsr_pkg::DEPTH];
  logic [bsr_pkg::DEPTH-1:0]  model_written;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      model_written <= {bsr_pkg::DEPTH{1'h0}};
    end
    else if (ram_we)
    begin
      model_written[adr_i] <= 1'h1;
    end
  end

  // Bytes kept without reset, as in the RAM itself
  always_ff @(posedge core_clk)
  begin
    if (ram_we)
    begin
      model_mem[adr_i] <= dat_i;
    end
  end

  // Any read of a written location returns the byte last stored there
  model_readback_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ack_o && is_read(stb_i, we_i) && model_written[adr_i] |-> dat_o == model_mem[adr_i])
    else $error("read returned a byte other than the last one written");

  write_readback_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ack_o && !we_i && shadow_valid && adr_i == shadow_addr |-> dat_o == shadow_data)
    else $error("read after write returned wrong byte");

  // Handshake checks: writes never wait, and nothing answers an idle bus
  write_ack_now_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    stb_i && we_i |-> ack_o)
    else $error("write not acknowledged in strobe cycle");

  ack_needs_stb_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ack_o |-> stb_i)
    else $error("acknowledge without strobe");

  zero_wait_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !SYNC_READ && stb_i && !we_i |-> ack_o)
    else $error("asynchronous read form delayed acknowledge");

  // Registered reads: first strobe cycle waits, the next one answers
  read_wait_first_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    SYNC_READ && is_read(stb_i, we_i) && (!$past(stb_i) || $past(we_i) || $past(ack_o))
    |-> !ack_o)
    else $error("registered read acknowledged without wait");

  read_ack_next_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    SYNC_READ && stb_i && !we_i && !ack_o |=> (!stb_i || we_i || ack_o))
    else $error("registered read wait longer than one cycle");

  wait_single_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rd_state == bsr_pkg::BSR_RD_WAIT |=> rd_state == bsr_pkg::BSR_RD_IDLE)
    else $error("read wait state held too long");

  // Strobe held over a block read: every second edge answers
  block_read_pace_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    SYNC_READ && (stb_i && !we_i) [*4] |-> $countones({ack_o, $past(ack_o)}) == 1)
    else $error("block read acknowledge pacing wrong");

endmodule

// >>> verif/bsr_master_model.sv
`timescale 1ns/100ps
// Bus master wired straight to the RAM; one request at a time
module bsr_master_model
(
  input  wire logic       core_clk,
  output logic      [3:0] adr,
  output logic      [7:0] dat,
  output logic            stb,
  output logic            we,
  input  wire logic       ack
);
  initial
  begin
    {stb, we, adr, dat} = 14'h0;
  end
  // Held until acknowledged, for at most four edges, then scrambled so stale values never pass
  task automatic xfer(input bit w, input logic [3:0] a, input logic [7:0] v, output int n);
    n = 0;
    @(posedge core_clk);
    {stb, we, adr, dat} <= {1'b1, w, a, v};
    for (int i = 1; i <= 4 && n == 0; i++)
    begin
      @(posedge core_clk);
      if (ack)
        n = i;
    end
    {stb, we, adr, dat} <= {1'b0, ~w, ~a, ~v};
  endtask
  // Block cycle: strobe stays up, address and data step on at each acknowledge
  task automatic xfer_block(input bit w, input logic [3:0] a, input logic [7:0] v,
                            input int cnt, output int n);
    int k;
    n = 0;
    k = 0;
    @(posedge core_clk);
    {stb, we, adr, dat} <= {1'b1, w, a, v};
    for (int i = 1; i <= 4 * cnt && k < cnt; i++)
    begin
      @(posedge core_clk);
      n = i;
      if (ack)
        k++;
      if (ack && k < cnt && i < 4 * cnt)
        {adr, dat} <= {4'(a + k), 8'(v + k)};
    end
    if (k < cnt)
      n = 0;
    {stb, we, adr, dat} <= {1'b0, ~w, ~a, ~v};
  endtask
endmodule

// >>> verif/bus_slave_sixteen_byte_ram_tb.sv
`timescale 1ns/100ps
// Both read forms run the same single transfers side by side; block cycles run one lane at a time
module bus_slave_sixteen_byte_ram_tb;
  logic       core_clk;
  logic       reset_n;
  logic [3:0] adr [2];
  logic [7:0] dat_i [2];
  logic [7:0] dat_o [2];
  logic       stb [2];
  logic       we [2];
  logic       ack [2];
  logic [7:0] mem [2][16];
  logic [7:0] exp_q [2][$];
  int         fail_count;
  int         comparisons;

  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    bsr_master_model i_bsr_master_model
    (.core_clk(core_clk), .adr(adr[g]), .dat(dat_i[g]), .stb(stb[g]), .we(we[g]), .ack(ack[g]));
    bsr_ram16x8 #(.SYNC_READ(g == 1)) i_bsr_ram16x8
    (.core_clk(core_clk), .reset_n(reset_n), .adr_i(adr[g]), .dat_i(dat_i[g]),
     .dat_o(dat_o[g]), .stb_i(stb[g]), .we_i(we[g]), .ack_o(ack[g]));
    // An acknowledged read meets the oldest expected byte
    always @(posedge core_clk)
      if (stb[g] && ack[g] && !we[g])
      begin
        comparisons++;
        if (exp_q[g].size() == 0 || dat_o[g] !== exp_q[g].pop_front())
        begin
          $display("ERROR %0t lane %0d read data", $time, g);
          fail_count++;
        end
      end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Wait length per kind; a zero count means no answer came
  task automatic op(input int g, input bit w, input logic [3:0] a, input logic [7:0] v);
    int n;
    if (w)
      mem[g][a] = v;
    else
      exp_q[g].push_back(mem[g][a]);
    if (g == 0)
      g_lane[0].i_bsr_master_model.xfer(w, a, v, n);
    else
      g_lane[1].i_bsr_master_model.xfer(w, a, v, n);
    comparisons++;
    if (n != (w ? 1 : 1 + g))
    begin
      $display("ERROR %0t lane %0d ack after %0d edges", $time, g, n);
      fail_count++;
      if (n == 0)
        tally_and_finish();
    end
  endtask

  // Block cycles on one lane; edges expected follow the lane's read form
  task automatic blk(input int g, input bit w, input logic [3:0] a, input logic [7:0] v,
                     input int cnt);
    int n;
    for (int k = 0; k < cnt; k++)
      if (w)
        mem[g][4'(a + k)] = 8'(v + k);
      else
        exp_q[g].push_back(mem[g][4'(a + k)]);
    if (g == 0)
      g_lane[0].i_bsr_master_model.xfer_block(w, a, v, cnt, n);
    else
      g_lane[1].i_bsr_master_model.xfer_block(w, a, v, cnt, n);
    comparisons++;
    if (n != (w ? cnt : cnt * (1 + g)))
    begin
      $display("ERROR %0t lane %0d block took %0d edges", $time, g, n);
      fail_count++;
      if (n == 0)
        tally_and_finish();
    end
  endtask

  task automatic both(input bit w, input logic [3:0] a, input logic [7:0] v);
    fork
      op(0, w, a, v);
      op(1, w, a, v);
    join
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever
      #5 core_clk = ~core_clk;
  end

  // Fill, read back, modify in place, then check contents outlive a reset
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    reset_n = 1'b0;
    void'($urandom(32'h25470AC5));
    repeat (12)
      @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      both(1'b1, 4'(i), 8'($urandom));
    for (int i = 15; i >= 0; i--)
      both(1'b0, 4'(i), 8'h00);
    $display("test fill and read done");
    for (int i = 0; i < 6; i++)
    begin
      both(1'b0, 4'(i * 5), 8'h00);
      both(1'b1, 4'(i * 5), 8'($urandom));
      both(1'b0, 4'(i * 5), 8'h00);
    end
    $display("test read-modify-write done");
    for (int g = 0; g < 2; g++)
    begin
      blk(g, 1'b1, 4'(g * 7), 8'($urandom), 6);
      blk(g, 1'b0, 4'(g * 7), 8'h00, 6);
    end
    $display("test block cycles done");
    reset_n <= 1'b0;
    repeat (2)
      @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      both(1'b0, 4'(i), 8'h00);
    $display("test contents across reset done");
    tally_and_finish();
  end
endmodule
